// ---- rtl/tick_pkg.sv ----
// Package with register map, field layout and reset values of the periodic tick counter
package tick_pkg;
    localparam logic [7:0] OFS_STATUS = 8'h00;
    localparam logic [7:0] OFS_CONTROL = 8'h04;
    localparam logic [7:0] OFS_COUNT = 8'h08;
    localparam logic [7:0] OFS_WRAP = 8'h0c;
    localparam logic [7:0] OFS_MASK = 8'h10;
    localparam int CTL_PS_LSB = 0;
    localparam int CTL_SRC_LSB = 4;
    localparam logic [3:0] PS_RESET = 4'h0;
    localparam logic [1:0] SRC_RESET = 2'h0;
    localparam logic [7:0] WRAP_RESET = 8'h00;
    localparam logic [7:0] COUNT_RESET = 8'h00;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

    typedef enum logic [1:0] {
        SRC_LPO,
        SRC_EXT,
        SRC_INT,
        SRC_NONE
    } tick_src_e;

    typedef struct packed {
        logic [1:0] source;
        logic [3:0] prescale;
    } tick_ctl_s;
endpackage : tick_pkg

// ---- rtl/periodic_tick_counter.sv ----
// Periodic tick counter with prescaler, AHB-Lite register slave and match interrupt
`timescale 1ns/1ps
`default_nettype none

// Contract
// - Count prescaler edges; on count equal to wrap limit clear count, set match flag.
// - Wrap limit zero sets the match flag on every prescaler output edge.
// - Writing the wrap limit clears prescaler and counter.
// - Reset loads wrap limit with zero.
// - Count register reads current count; writes ignored.
// - Writing a different source or prescale select clears counter and prescaler.
// - After reset counter stopped at zero, prescaler off, wrap limit zero.
// - Reset selects the low-power oscillator as tick source.
// - Prescaler off while prescale select zero; runs once nonzero.
// - Source select picks low-power, external reference or internal clock.
// - Prescaler offers binary and decimal divide ratios.
// - Counting continues in wait mode when enabled.
// - Counting continues in shallow stop when enabled; in deep stop only from the low-power clock.
// - Low-power clock usable in both stop modes; others only in shallow stop.
// - Background debug freezes counting; resumes from frozen value.
// - Match interrupt can be enabled or disabled by software.
// - With all sources disabled there is no counting and no wake.
module periodic_tick_counter (
    input wire logic CLK,
    input wire logic SYS_RST,
    input wire logic HSEL,
    input wire logic [7:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    input wire logic LOW_POWER_OSC_CLOCK,
    input wire logic EXTERNAL_REF_CLOCK,
    input wire logic INTERNAL_REF_CLOCK,
    input wire logic WAIT_MODE,
    input wire logic STOP_SHALLOW,
    input wire logic STOP_DEEP,
    input wire logic DEBUG_ACTIVE,
    output logic TICK_IRQ
);
    logic ph_write;
    logic ph_read;
    logic [7:0] ph_addr;
    tick_pkg::tick_ctl_s ctl;
    logic [7:0] tick_wrap_limit;
    logic [7:0] tick_count_value;
    logic [15:0] prescaler;
    logic [15:0] ps_limit;
    logic tick_match_flag;
    logic irq_mask;
    logic [2:0] src_pins;
    logic [2:0] src_prev;
    logic [2:0] src_rise;
    logic src_edge;
    logic src_avail;
    logic ps_out;
    logic wr_en;
    logic wr_wrap;
    logic wr_ctl;
    logic ctl_change;
    logic flag_clear;
    logic run;
    logic match_hit;
    tick_pkg::tick_ctl_s next_ctl;

    assign wr_en = ph_write;
    assign wr_wrap = wr_en && ph_addr == tick_pkg::OFS_WRAP;
    assign wr_ctl = wr_en && ph_addr == tick_pkg::OFS_CONTROL;
    assign next_ctl.prescale = HWDATA[tick_pkg::CTL_PS_LSB +: 4];
    assign next_ctl.source = HWDATA[tick_pkg::CTL_SRC_LSB +: 2];
    assign ctl_change = wr_ctl && (next_ctl != ctl);
    assign flag_clear = wr_en && ph_addr == tick_pkg::OFS_STATUS && HWDATA[0];

    // Address phase capture; one wait-free data phase
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            ph_write <= 1'b0;
            ph_read <= 1'b0;
            ph_addr <= 8'h00;
        end else if (HREADY) begin
            ph_write <= HSEL && HTRANS == tick_pkg::HTRANS_NONSEQ && HWRITE;
            ph_read <= HSEL && HTRANS == tick_pkg::HTRANS_NONSEQ && !HWRITE;
            ph_addr <= HADDR;
        end else begin
            ph_write <= 1'b0;
            ph_read <= 1'b0;
        end
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            HREADYOUT <= 1'b1;
            HRESP <= 1'b0;
        end else begin
            HREADYOUT <= 1'b1;
            HRESP <= 1'b0;
        end
    end

    // Read data registered at the address phase so it is ready in the data phase
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            HRDATA <= 32'h0000_0000;
        end else if (HREADY && HSEL && HTRANS == tick_pkg::HTRANS_NONSEQ && !HWRITE) begin
            case (HADDR)
                tick_pkg::OFS_STATUS: HRDATA <= {31'h0000_0000, tick_match_flag};
                tick_pkg::OFS_CONTROL: HRDATA <= {26'h000_0000, ctl.source, ctl.prescale};
                tick_pkg::OFS_COUNT: HRDATA <= {24'h00_0000, tick_count_value};
                tick_pkg::OFS_WRAP: HRDATA <= {24'h00_0000, tick_wrap_limit};
                tick_pkg::OFS_MASK: HRDATA <= {31'h0000_0000, irq_mask};
                default: HRDATA <= 32'h0000_0000;
            endcase
        end
    end

    // Configuration registers
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            tick_wrap_limit <= tick_pkg::WRAP_RESET;
            ctl.prescale <= tick_pkg::PS_RESET;
            ctl.source <= tick_pkg::SRC_RESET;
            irq_mask <= 1'b0;
        end else begin
            if (wr_wrap) begin
                tick_wrap_limit <= HWDATA[7:0];
            end
            if (wr_ctl) begin
                ctl <= next_ctl;
            end
            if (wr_en && ph_addr == tick_pkg::OFS_MASK) begin
                irq_mask <= HWDATA[0];
            end
        end
    end

    // Source selection and availability in low-power modes
    always_comb begin
        case (tick_pkg::tick_src_e'(ctl.source))
            tick_pkg::SRC_LPO: begin
                src_edge = src_rise[0];
                src_avail = 1'b1;
            end
            tick_pkg::SRC_EXT: begin
                src_edge = src_rise[1];
                src_avail = !STOP_DEEP;
            end
            tick_pkg::SRC_INT: begin
                src_edge = src_rise[2];
                src_avail = !STOP_DEEP;
            end
            default: begin
                src_edge = 1'b0;
                src_avail = 1'b0;
            end
        endcase
    end

    // Wait and shallow stop do not gate counting; debug freezes it
    assign run = ctl.prescale != 4'h0 && src_avail && !DEBUG_ACTIVE;

    assign src_pins = {INTERNAL_REF_CLOCK, EXTERNAL_REF_CLOCK, LOW_POWER_OSC_CLOCK};

    // One detector per source, so switching source never fakes an edge
    for (genvar i = 0; i < 3; i++) begin : g_src
        always_ff @(posedge CLK) begin
            if (SYS_RST) begin
                src_prev[i] <= 1'b0;
            end else begin
                src_prev[i] <= src_pins[i];
            end
        end

        assign src_rise[i] = src_pins[i] && !src_prev[i];
    end

    // Codes 1..7 binary (8, then 32 up to 1024), 8..15 decimal steps
    always_comb begin
        case (ctl.prescale)
            4'h1: ps_limit = 16'h0007;
            4'h2: ps_limit = 16'h001f;
            4'h3: ps_limit = 16'h003f;
            4'h4: ps_limit = 16'h007f;
            4'h5: ps_limit = 16'h00ff;
            4'h6: ps_limit = 16'h01ff;
            4'h7: ps_limit = 16'h03ff;
            4'h8: ps_limit = 16'h0000;
            4'h9: ps_limit = 16'h0001;
            4'ha: ps_limit = 16'h0004;
            4'hb: ps_limit = 16'h0009;
            4'hc: ps_limit = 16'h0013;
            4'hd: ps_limit = 16'h0031;
            4'he: ps_limit = 16'h0063;
            4'hf: ps_limit = 16'h03e7;
            default: ps_limit = 16'h0000;
        endcase
    end

    assign ps_out = run && src_edge && prescaler == ps_limit;

    always_ff @(posedge CLK) begin
        if (SYS_RST || wr_wrap || ctl_change) begin
            prescaler <= 16'h0000;
        end else if (run && src_edge) begin
            prescaler <= (prescaler == ps_limit) ? 16'h0000 : prescaler + 16'h0001;
        end
    end

    assign match_hit = ps_out && tick_count_value == tick_wrap_limit;

    always_ff @(posedge CLK) begin
        if (SYS_RST || wr_wrap || ctl_change) begin
            tick_count_value <= tick_pkg::COUNT_RESET;
        end else if (match_hit) begin
            tick_count_value <= 8'h00;
        end else if (ps_out) begin
            tick_count_value <= tick_count_value + 8'h01;
        end
    end

    // Set wins over a simultaneous write-one-to-clear
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            tick_match_flag <= 1'b0;
        end else if (match_hit) begin
            tick_match_flag <= 1'b1;
        end else if (flag_clear) begin
            tick_match_flag <= 1'b0;
        end
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            TICK_IRQ <= 1'b0;
        end else begin
            TICK_IRQ <= (tick_match_flag || match_hit) && irq_mask;
        end
    end
endmodule : periodic_tick_counter

`default_nettype wire

// ---- dv/periodic_tick_counter_assertions.sv ----
// Port-level checks of the tick counter bus and interrupt
`timescale 1ns/1ps
`default_nettype none
module tick_chk (
    input wire logic CLK,
    input wire logic SYS_RST,
    input wire logic HSEL,
    input wire logic [7:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic HREADY,
    input wire logic [31:0] HRDATA,
    input wire logic HREADYOUT,
    input wire logic HRESP,
    input wire logic TICK_IRQ
);
    default clocking @(posedge CLK); endclocking
    default disable iff (SYS_RST);
    logic tk, rd, wr;
    assign tk = HSEL && HREADY && HTRANS == tick_pkg::HTRANS_NONSEQ;
    assign rd = tk && !HWRITE;
    assign wr = tk && HWRITE;
    sequence s_rd_unmap;
        rd && !(HADDR inside {8'h00, 8'h04, 8'h08, 8'h0c, 8'h10});
    endsequence
    sequence s_rd_byte;
        rd && (HADDR == 8'h08 || HADDR == 8'h0c);
    endsequence
    sequence s_rd_bit;
        rd && (HADDR == 8'h00 || HADDR == 8'h10);
    endsequence
    a_ready_high: assert property (HREADYOUT) else $error("hreadyout low");
    a_resp_okay: assert property (!HRESP) else $error("hresp not okay");
    a_reset_quiet: assert property (
        disable iff (1'b0) SYS_RST |=> HRDATA == 32'h0 && !TICK_IRQ)
        else $error("outputs not cleared by reset");
    a_unmap_zero: assert property (s_rd_unmap |=> HRDATA == 32'h0)
        else $error("unmapped read not zero");
    a_byte_upper: assert property (s_rd_byte |=> HRDATA[31:8] == 24'h0)
        else $error("count or wrap upper bits set");
    a_bit_upper: assert property (s_rd_bit |=> HRDATA[31:1] == 31'h0)
        else $error("status or mask upper bits set");
    a_data_stands: assert property ($changed(HRDATA) && !$past(SYS_RST) |-> $past(rd))
        else $error("read data moved without a read");
    // Address phase, data phase, then the registered request: three edges back
    a_irq_clear: assert property ($fell(TICK_IRQ) && !$past(SYS_RST) |-> $past(wr, 3))
        else $error("interrupt dropped without a write");
endmodule : tick_chk
bind periodic_tick_counter tick_chk i_chk (.*);
`default_nettype wire

// ---- dv/test_periodic_tick_counter.sv ----
// Register-level bench of the periodic tick counter
`timescale 1ns/1ps
`default_nettype none
module test_periodic_tick_counter;
    logic clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
    logic dbg = 1'b0, deep = 1'b0, wt = 1'b0, shl = 1'b0, hready, irq, hresp;
    logic [7:0] haddr = 8'h00;
    logic [1:0] htrans = 2'h0;
    logic [2:0] src = 3'h0;
    logic [31:0] hwdata = 32'h0, q, hrdata;
    int num_errors = 0, num_checks = 0;
    periodic_tick_counter i_dut (.CLK(clk), .SYS_RST(rst), .HSEL(hsel), .HADDR(haddr),
        .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hready),
        .HRDATA(hrdata), .HREADYOUT(hready), .HRESP(hresp), .LOW_POWER_OSC_CLOCK(src[0]),
        .EXTERNAL_REF_CLOCK(src[1]), .INTERNAL_REF_CLOCK(src[2]), .WAIT_MODE(wt),
        .STOP_SHALLOW(shl), .STOP_DEEP(deep), .DEBUG_ACTIVE(dbg), .TICK_IRQ(irq));
    initial forever #10 clk = ~clk;
    task test_done;
        if (num_errors == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : test_done
    task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("FAIL %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task rdy;
        for (int i = 0; i < 20; i++) begin
            @(posedge clk);
            if (hready === 1'b1)
                return;
        end
        num_errors++;
        test_done;
    endtask : rdy
    task bus(input logic [7:0] a, input logic w, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= tick_pkg::HTRANS_NONSEQ;
        rdy;
        htrans <= 2'h0;
        hwdata <= d;
        rdy;
        q = hrdata;
    endtask : bus
    task rd(input string nm, input logic [7:0] a, input logic [31:0] e);
        bus(a, 1'b0, 32'h0);
        chk(nm, q, e);
    endtask : rd
    task cnt(input logic [31:0] e);
        rd("count", tick_pkg::OFS_COUNT, e);
    endtask : cnt
    task ctl(input logic [31:0] d);
        bus(tick_pkg::OFS_CONTROL, 1'b1, d);
    endtask : ctl
    // Source edges are two cycles wide so the edge detector sees each one
    task pulse(input logic [2:0] s, input int n);
        repeat (n) begin
            src <= s;
            repeat (2) @(posedge clk);
            src <= 3'h0;
            repeat (2) @(posedge clk);
        end
    endtask : pulse
    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        for (int i = 0; i < 6; i++)
            rd("reset", 8'(4 * i), 32'h0);
        ctl(32'h08);
        bus(tick_pkg::OFS_WRAP, 1'b1, 32'h03);
        pulse(3'h1, 3);
        cnt(32'h03);
        rd("flag", tick_pkg::OFS_STATUS, 32'h0);
        pulse(3'h1, 1);
        cnt(32'h00);
        rd("flag", tick_pkg::OFS_STATUS, 32'h1);
        bus(tick_pkg::OFS_MASK, 1'b1, 32'h1);
        repeat (2) @(posedge clk);
        chk("irq", {31'h0, irq}, 32'h1);
        bus(tick_pkg::OFS_COUNT, 1'b1, 32'h55);
        cnt(32'h00);
        bus(tick_pkg::OFS_STATUS, 1'b1, 32'h1);
        repeat (2) @(posedge clk);
        chk("irq", {31'h0, irq}, 32'h0);
        bus(tick_pkg::OFS_WRAP, 1'b1, 32'h00);
        pulse(3'h1, 1);
        rd("flag", tick_pkg::OFS_STATUS, 32'h1);
        cnt(32'h00);
        bus(tick_pkg::OFS_WRAP, 1'b1, 32'h0a);
        pulse(3'h1, 2);
        dbg <= 1'b1;
        pulse(3'h1, 2);
        dbg <= 1'b0;
        pulse(3'h1, 1);
        cnt(32'h03);
        bus(tick_pkg::OFS_WRAP, 1'b1, 32'h0a);
        cnt(32'h00);
        ctl(32'h09);
        pulse(3'h1, 4);
        cnt(32'h02);
        ctl(32'h09);
        cnt(32'h02);
        ctl(32'h18);
        cnt(32'h00);
        deep <= 1'b1;
        pulse(3'h2, 2);
        cnt(32'h00);
        ctl(32'h08);
        pulse(3'h1, 1);
        cnt(32'h01);
        deep <= 1'b0;
        wt <= 1'b1;
        shl <= 1'b1;
        ctl(32'h18);
        pulse(3'h2, 1);
        cnt(32'h01);
        ctl(32'h28);
        pulse(3'h4, 1);
        cnt(32'h01);
        ctl(32'h38);
        pulse(3'h7, 2);
        cnt(32'h00);
        ctl(32'h00);
        pulse(3'h1, 2);
        cnt(32'h00);
        test_done;
    end
endmodule : test_periodic_tick_counter
`default_nettype wire
